// [design/ppa_pin_mux.sv]
// Purpose: per-pin ownership mux between latch and alternate function
// Assumes: alt function enable per pin comes from the top
// Notes:   one generate loop, one iteration per bit
`timescale 1ns/100ps
`default_nettype none
module ppa_pin_mux (
  // latch and alternate data
  input  wire logic [7:0] latchVal,
  input  wire logic [7:0] altOwn,
  input  wire logic [7:0] altOut,
  // resulting pin value
  output logic      [7:0] pinVal
);
  import ppa_pkg::*;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      // alternate drive only reaches the pin while the latch holds one
      assign pinVal[g] = altOwn[g] ? (latchVal[g] & altOut[g]) : latchVal[g];
    end
  endgenerate
endmodule
`default_nettype wire

// [design/ppa_pkg.sv]
// Purpose: shared constants for the parallel port and aux output block
// Assumes: core reaches registers over a byte-wide special register port
// Notes:   offsets are core register addresses
package ppa_pkg;
  localparam logic [7:0] PPA_ADDR_PORT0   = 8'h80;
  localparam logic [7:0] PPA_ADDR_PORT1   = 8'h90;
  localparam logic [7:0] PPA_ADDR_PORT2   = 8'hA0;
  localparam logic [7:0] PPA_ADDR_PORT3   = 8'hB0;
  localparam logic [7:0] PPA_ADDR_AUXCTL  = 8'hE8;
  localparam logic [7:0] PPA_RST_LATCH    = 8'hFF;
  localparam logic [7:0] PPA_RST_PORT1    = 8'hFF;
  localparam logic [7:0] PPA_RST_AUXCTL   = 8'h00;
  localparam int         PPA_BIT_B_VALUE  = 7;
  localparam int         PPA_BIT_B_ENABLE = 6;
  localparam int         PPA_BIT_A_VALUE  = 5;
  localparam int         PPA_BIT_A_ENABLE = 4;
  localparam logic [7:0] PPA_P1_ALT_MASK  = 8'h23;
  localparam logic [7:0] PPA_P3_ALT_MASK  = 8'hFF;
  typedef enum logic [1:0] {PPA_BUS_IDLE, PPA_BUS_ADDR, PPA_BUS_DATA} ppa_bus_t;
endpackage

// [design/ppa_ports.sv]
// Purpose: four parallel ports and two auxiliary outputs behind core registers
// Assumes: core register port strobes are single-cycle, same clock
// Notes:   pin level read back; pull-ups are pad-side, not modelled here
//
// Functional notes
// - aux pads carry serial signals when enabled
// - bit 7 drives aux pin b value
// - bit 6 enables aux pin b
// - bit 5 drives aux pin a value
// - bit 4 enables aux pin a, reset zero
// - enabled peripheral takes its pins
// - port zero open drain, one floats
// - external bus drives port zero both ways
// - port one input only, no drive
// - port one resets ones, zero digital
// - port one alternate inputs on 0,1,5
// - port two latch one pulls high
// - port two carries upper address bytes
// - port three latch one pulls high
// - port three carries serial, interrupt, strobes
// - alternate works only with latch one
// - serial enable frees pads when cleared
`timescale 1ns/100ps
`default_nettype none
module ppa_ports (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // core register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            regHit,
  // serial interface sharing the aux pads
  input  wire logic       serialIfaceEnable,
  input  wire logic [1:0] serialPadOut,
  input  wire logic [1:0] serialPadOe,
  output logic      [1:0] serialPadIn,
  // external memory bus
  input  wire logic       extBusActive,
  input  wire logic       extBusAddrPhase,
  input  wire logic       extBusWrite,
  input  wire logic       extBusWide,
  input  wire logic [23:0] extBusAddr,
  input  wire logic [7:0] extBusWdata,
  output logic      [7:0] extBusRdata,
  // alternate functions
  input  wire logic       altPort3Enable,
  input  wire logic [7:0] port3AltOut,
  output logic      [7:0] port1AltIn,
  output logic      [7:0] port3AltIn,
  // port zero pins
  input  wire logic [7:0] port0In,
  output logic      [7:0] port0Out,
  output logic      [7:0] port0Oe,
  // port one pins
  input  wire logic [7:0] port1In,
  output logic      [7:0] port1AnalogSel,
  // port two pins
  input  wire logic [7:0] port2In,
  output logic      [7:0] port2Out,
  output logic      [7:0] port2Oe,
  // port three pins
  input  wire logic [7:0] port3In,
  output logic      [7:0] port3Out,
  output logic      [7:0] port3Oe,
  // aux pads
  input  wire logic [1:0] auxPadIn,
  output logic      [1:0] auxPadOut,
  output logic      [1:0] auxPadOe
);
  import ppa_pkg::*;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [7:0] aux;
    logic [7:0] rdata;
    logic       hit;
    ppa_bus_t   busPh;
    logic [7:0] midByte;
  } ppa_st_t;

  ppa_st_t    st_r;
  ppa_st_t    st_nxt;
  logic [7:0] lvl0;
  logic [7:0] lvl1;
  logic [7:0] lvl2;
  logic [7:0] lvl3;
  logic [7:0] p3Pin;
  logic [7:0] p3Own;
  logic       auxBEn;
  logic       auxAEn;
  logic       wrHit;

  ppa_sync u_sync0 (.ref_clk(ref_clk), .resetn(resetn), .pinIn(port0In), .pinLevel(lvl0));
  ppa_sync u_sync1 (.ref_clk(ref_clk), .resetn(resetn), .pinIn(port1In), .pinLevel(lvl1));
  ppa_sync u_sync2 (.ref_clk(ref_clk), .resetn(resetn), .pinIn(port2In), .pinLevel(lvl2));
  ppa_sync u_sync3 (.ref_clk(ref_clk), .resetn(resetn), .pinIn(port3In), .pinLevel(lvl3));

  assign p3Own = altPort3Enable ? PPA_P3_ALT_MASK : 8'h00;
  ppa_pin_mux u_mux3 (
    .latchVal (st_r.p3),
    .altOwn   (p3Own),
    .altOut   (port3AltOut),
    .pinVal   (p3Pin)
  );

  assign wrHit = regWr && (regAddr == PPA_ADDR_PORT0 || regAddr == PPA_ADDR_PORT1 ||
                           regAddr == PPA_ADDR_PORT2 || regAddr == PPA_ADDR_PORT3 ||
                           regAddr == PPA_ADDR_AUXCTL);

  always_comb begin
    st_nxt     = st_r;
    st_nxt.hit = 1'b0;
    if (regWr) begin
      case (regAddr)
        PPA_ADDR_PORT0:  st_nxt.p0  = regWdata;
        PPA_ADDR_PORT1:  st_nxt.p1  = regWdata;
        PPA_ADDR_PORT2:  st_nxt.p2  = regWdata;
        PPA_ADDR_PORT3:  st_nxt.p3  = regWdata;
        PPA_ADDR_AUXCTL: st_nxt.aux = regWdata;
        default:         st_nxt.p0  = st_r.p0;
      endcase
      st_nxt.hit = wrHit;
    end else if (regRd) begin
      // pins are read, not latches; the control register reads itself
      st_nxt.hit = 1'b1;
      case (regAddr)
        PPA_ADDR_PORT0:  st_nxt.rdata = lvl0;
        PPA_ADDR_PORT1:  st_nxt.rdata = lvl1;
        PPA_ADDR_PORT2:  st_nxt.rdata = lvl2;
        PPA_ADDR_PORT3:  st_nxt.rdata = lvl3;
        PPA_ADDR_AUXCTL: st_nxt.rdata = st_r.aux;
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.hit   = 1'b0;
        end
      endcase
    end
    // external bus phase tracking
    case (st_r.busPh)
      PPA_BUS_IDLE: begin
        if (extBusActive) begin
          st_nxt.busPh = extBusAddrPhase ? PPA_BUS_ADDR : PPA_BUS_DATA;
        end
      end
      PPA_BUS_ADDR, PPA_BUS_DATA: begin
        if (!extBusActive) begin
          st_nxt.busPh = PPA_BUS_IDLE;
        end else begin
          st_nxt.busPh = extBusAddrPhase ? PPA_BUS_ADDR : PPA_BUS_DATA;
        end
      end
      default: st_nxt.busPh = PPA_BUS_IDLE;
    endcase
    if (extBusActive && extBusAddrPhase) begin
      st_nxt.midByte = extBusAddr[15:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r.p0      <= PPA_RST_LATCH;
      st_r.p1      <= PPA_RST_PORT1;
      st_r.p2      <= PPA_RST_LATCH;
      st_r.p3      <= PPA_RST_LATCH;
      st_r.aux     <= PPA_RST_AUXCTL;
      st_r.rdata   <= 8'h00;
      st_r.hit     <= 1'b0;
      st_r.busPh   <= PPA_BUS_IDLE;
      st_r.midByte <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign regHit   = st_r.hit;

  // port zero: open drain as gpio, push-pull as bus
  always_comb begin
    if (extBusActive) begin
      port0Out = extBusAddrPhase ? extBusAddr[7:0] : extBusWdata;
      port0Oe  = (extBusAddrPhase || extBusWrite) ? 8'hFF : 8'h00;
    end else begin
      port0Out = 8'h00;
      port0Oe  = ~st_r.p0;
    end
  end
  assign extBusRdata = lvl0;

  // port one: never driven; analog select straight from the latch
  assign port1AnalogSel = st_r.p1;
  assign port1AltIn     = lvl1 & st_r.p1 & PPA_P1_ALT_MASK;

  // port two: as gpio, latch one means pull-up only, so drive only zeros; as bus, drive all pins
  always_comb begin
    if (extBusActive) begin
      // middle byte of a wide access is held from its address phase
      if (!extBusWide) begin
        port2Out = extBusAddr[15:8];
      end else if (extBusAddrPhase || st_r.busPh == PPA_BUS_IDLE) begin
        port2Out = extBusAddr[23:16];
      end else begin
        port2Out = st_r.midByte;
      end
      port2Oe  = 8'hFF;
    end else begin
      port2Out = st_r.p2;
      port2Oe  = ~st_r.p2;
    end
  end

  // port three: strobes and serial are alternates gated by the latch
  assign port3Out   = p3Pin;
  assign port3Oe    = ~p3Pin;
  assign port3AltIn = lvl3 & st_r.p3;

  // aux pads: serial wins whenever enabled
  assign auxBEn = st_r.aux[PPA_BIT_B_ENABLE];
  assign auxAEn = st_r.aux[PPA_BIT_A_ENABLE];
  always_comb begin
    if (serialIfaceEnable) begin
      auxPadOut = serialPadOut;
      auxPadOe  = serialPadOe;
    end else begin
      auxPadOut = {st_r.aux[PPA_BIT_B_VALUE] & auxBEn,
                   st_r.aux[PPA_BIT_A_VALUE] & auxAEn};
      auxPadOe  = {auxBEn, auxAEn};
    end
  end
  assign serialPadIn = serialIfaceEnable ? auxPadIn : 2'b00;

  property p_aux_b_drive;
    @(posedge ref_clk) disable iff (!resetn)
      (!serialIfaceEnable && st_r.aux[PPA_BIT_B_ENABLE]) |-> auxPadOe[1] &&
        (auxPadOut[1] == st_r.aux[PPA_BIT_B_VALUE]);
  endproperty
  a_aux_b_drive: assert property (p_aux_b_drive) else $error("aux b not driven");

  property p_aux_b_off;
    @(posedge ref_clk) disable iff (!resetn)
      (!serialIfaceEnable && !st_r.aux[PPA_BIT_B_ENABLE]) |-> !auxPadOe[1];
  endproperty
  a_aux_b_off: assert property (p_aux_b_off) else $error("aux b enabled wrongly");

  property p_aux_a_drive;
    @(posedge ref_clk) disable iff (!resetn)
      (!serialIfaceEnable) |-> (auxPadOe[0] == st_r.aux[PPA_BIT_A_ENABLE]) &&
        (auxPadOut[0] == (st_r.aux[PPA_BIT_A_VALUE] && st_r.aux[PPA_BIT_A_ENABLE]));
  endproperty
  a_aux_a_drive: assert property (p_aux_a_drive) else $error("aux a enable wrong");

  property p_aux_reset;
    @(posedge ref_clk) !resetn |=> (st_r.aux == 8'h00);
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux ctl not zero after reset");

  property p_serial_owns;
    @(posedge ref_clk) disable iff (!resetn)
      serialIfaceEnable |-> (auxPadOe == serialPadOe) && (auxPadOut == serialPadOut);
  endproperty
  a_serial_owns: assert property (p_serial_owns) else $error("serial lost pads");

  sequence s_wr_p0;
    regWr && regAddr == PPA_ADDR_PORT0 && !extBusActive;
  endsequence
  property p_p0_float;
    @(posedge ref_clk) disable iff (!resetn)
      s_wr_p0 ##1 !extBusActive |-> port0Oe == ~$past(regWdata);
  endproperty
  a_p0_float: assert property (p_p0_float) else $error("port zero drive wrong");

  property p_p1_reset;
    @(posedge ref_clk) !resetn |=> port1AnalogSel == 8'hFF;
  endproperty
  a_p1_reset: assert property (p_p1_reset) else $error("port one not analog at reset");

  sequence s_rd_p2;
    regRd && !regWr && regAddr == PPA_ADDR_PORT2;
  endsequence
  property p_read_pin;
    @(posedge ref_clk) disable iff (!resetn)
      s_rd_p2 |=> regRdata == $past(lvl2) && regHit;
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("read not pin level");

  property p_p3_stuck;
    @(posedge ref_clk) disable iff (!resetn)
      (!st_r.p3[6]) |-> !port3Out[6] && port3Oe[6];
  endproperty
  a_p3_stuck: assert property (p_p3_stuck) else $error("port three pin not held low");

  property p_p0_bus_addr;
    @(posedge ref_clk) disable iff (!resetn)
      (extBusActive && extBusAddrPhase) |-> (port0Oe == 8'hFF) && (port0Out == extBusAddr[7:0]);
  endproperty
  a_p0_bus_addr: assert property (p_p0_bus_addr) else $error("bus address off p0");

  property p_p0_bus_wdata;
    @(posedge ref_clk) disable iff (!resetn)
      (extBusActive && !extBusAddrPhase && extBusWrite) |->
        (port0Oe == 8'hFF) && (port0Out == extBusWdata);
  endproperty
  a_p0_bus_wdata: assert property (p_p0_bus_wdata) else $error("bus data off p0");

  property p_p2_bus_addr;
    @(posedge ref_clk) disable iff (!resetn)
      (extBusActive && extBusAddrPhase) |-> (port2Oe == 8'hFF) &&
        (port2Out == (extBusWide ? extBusAddr[23:16] : extBusAddr[15:8]));
  endproperty
  a_p2_bus_addr: assert property (p_p2_bus_addr) else $error("upper address off p2");

  sequence s_wide_addr;
    extBusActive && extBusAddrPhase && extBusWide;
  endsequence
  property p_p2_mid;
    @(posedge ref_clk) disable iff (!resetn)
      s_wide_addr ##1 (extBusActive && !extBusAddrPhase && extBusWide) |->
        port2Out == $past(extBusAddr[15:8]);
  endproperty
  a_p2_mid: assert property (p_p2_mid) else $error("middle byte off p2");

  property p_p2_gpio;
    @(posedge ref_clk) disable iff (!resetn)
      !extBusActive |-> ((port2Out & port2Oe) == 8'h00) && (port2Oe == ~st_r.p2);
  endproperty
  a_p2_gpio: assert property (p_p2_gpio) else $error("p2 drives a one");

  property p_p3_pull;
    @(posedge ref_clk) disable iff (!resetn)
      (port3Out & port3Oe) == 8'h00;
  endproperty
  a_p3_pull: assert property (p_p3_pull) else $error("p3 drives a one");

  property p_p3_alt_in;
    @(posedge ref_clk) disable iff (!resetn)
      (port3AltIn & ~st_r.p3) == 8'h00;
  endproperty
  a_p3_alt_in: assert property (p_p3_alt_in) else $error("p3 alternate leaked");

  property p_p1_alt_in;
    @(posedge ref_clk) disable iff (!resetn)
      (port1AltIn & ~(st_r.p1 & PPA_P1_ALT_MASK)) == 8'h00;
  endproperty
  a_p1_alt_in: assert property (p_p1_alt_in) else $error("p1 alternate leaked");

  property p_serial_free;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(serialIfaceEnable) |-> auxPadOe == {auxBEn, auxAEn};
  endproperty
  a_serial_free: assert property (p_serial_free) else $error("aux pads not freed");
endmodule
`default_nettype wire

// [design/ppa_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to ref_clk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ppa_sync (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // pins in, filtered level out
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinLevel
);
  import ppa_pkg::*;
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
  } ppa_sync_st_t;
  ppa_sync_st_t st_r;
  ppa_sync_st_t st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 8; i++) begin
      // level changes only once two late stages agree
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pinLevel = st_r.lvl;
endmodule
`default_nettype wire

// [verif/parallel_ports_and_aux_outputs_tb_top.sv]
// Purpose: self-checking bench for the parallel ports and aux outputs
// Assumes: pin levels settle within six cycles
// Notes:   expected register answers queue up, a monitor checks them
`timescale 1ns/100ps
`default_nettype none
module parallel_ports_and_aux_outputs_tb_top;
  import ppa_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, regHit;
  logic serialIfaceEnable = 1'b0, extBusActive = 1'b0, extBusAddrPhase = 1'b0;
  logic extBusWrite = 1'b0, extBusWide = 1'b0, altPort3Enable = 1'b0;
  logic [1:0] serialPadOut = 2'h0, serialPadOe = 2'h0, serialPadIn, auxPadIn, auxPadOut, auxPadOe;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, extBusWdata = 8'h00, port3AltOut = 8'h00;
  logic [7:0] port1In = 8'h00, pullLow = 8'h00, regRdata, extBusRdata, port1AltIn, port3AltIn;
  logic [7:0] port0In, port0Out, port0Oe, port1AnalogSel, port2In, port2Out, port2Oe;
  logic [7:0] port3In, port3Out, port3Oe, v, a, pl;
  logic [23:0] extBusAddr = 24'h000000;
  logic [8:0] expQ[$];
  logic [8:0] e;
  int seed = 50, nErrors = 0, cmpCount = 0, cycles = 0;

  ppa_ports i_ppa_ports (.ref_clk, .resetn, .regAddr, .regWr, .regRd, .regWdata, .regRdata,
    .regHit, .serialIfaceEnable, .serialPadOut, .serialPadOe, .serialPadIn, .extBusActive,
    .extBusAddrPhase, .extBusWrite, .extBusWide, .extBusAddr, .extBusWdata, .extBusRdata,
    .altPort3Enable, .port3AltOut, .port1AltIn, .port3AltIn, .port0In, .port0Out, .port0Oe,
    .port1In, .port1AnalogSel, .port2In, .port2Out, .port2Oe, .port3In, .port3Out, .port3Oe,
    .auxPadIn, .auxPadOut, .auxPadOe);
  ppa_pin_model i_ppa_pin_model (.ref_clk, .pullLow, .port0Out, .port0Oe, .port2Out,
    .port2Oe, .port3Out, .port3Oe, .auxPadOut, .auxPadOe, .port0In, .port2In, .port3In,
    .auxPadIn);

  always #2 ref_clk = ~ref_clk;

  function automatic logic [7:0] rnd8();
    int r;
    r = $random(seed);
    return r[7:0];
  endfunction
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: pin %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one register access; a mapped one queues its expected answer
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic hit);
    if (hit) expQ.push_back({~w, d});
    @(posedge ref_clk);
    regAddr <= ad;
    regWr <= w;
    regRd <= ~w;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge ref_clk);
  endtask
  // pins pass a three-stage synchroniser and a filter flop before they are seen
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      print_verdict();
    end else if (regHit === 1'b1) begin
      if (expQ.size() == 0) begin
        nErrors++;
        $display("mismatch at %0t: hit without access", $time);
      end else begin
        e = expQ.pop_front();
        if (e[8]) cmp_rd(regRdata, e[7:0]);
      end
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    cmp_pin({6'h00, auxPadOe}, 8'h00);
    cmp_pin(port1AnalogSel, 8'hFF);
    cmp_pin(port0Oe | port2Oe | port3Oe, 8'h00);
    acc(1'b0, PPA_ADDR_AUXCTL, 8'h00, 1'b1);
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], 4'h0};
      acc(1'b1, PPA_ADDR_AUXCTL, v, 1'b1);
      cmp_pin({6'h00, auxPadOe}, {6'h00, v[6], v[4]});
      cmp_pin({6'h00, auxPadOut & auxPadOe}, {6'h00, v[7] & v[6], v[5] & v[4]});
      acc(1'b0, PPA_ADDR_AUXCTL, v, 1'b1);
    end
    @(posedge ref_clk);
    serialIfaceEnable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = rnd8();
      @(posedge ref_clk);
      serialPadOut <= a[1:0];
      serialPadOe <= a[3:2];
      @(negedge ref_clk);
      cmp_pin({6'h00, auxPadOe}, {6'h00, a[3:2]});
      cmp_pin({6'h00, auxPadOut & a[3:2]}, {6'h00, a[1:0] & a[3:2]});
      cmp_pin({6'h00, serialPadIn}, {6'h00, auxPadIn});
    end
    @(posedge ref_clk);
    serialIfaceEnable <= 1'b0;
    @(negedge ref_clk);
    cmp_pin({2'h0, serialPadIn, auxPadOut, auxPadOe}, 8'h0F);
    for (int i = 0; i < 9; i++) begin
      v = rnd8();
      pl = rnd8();
      pullLow <= pl;
      a = (i % 3 == 0) ? PPA_ADDR_PORT0 : (i % 3 == 1) ? PPA_ADDR_PORT2 : PPA_ADDR_PORT3;
      acc(1'b1, a, v, 1'b1);
      cmp_pin((i % 3 == 0) ? port0Oe : (i % 3 == 1) ? port2Oe : port3Oe, ~v);
      cmp_pin(port0Out & port0Oe, 8'h00);
      cmp_pin(port2Out & port2Oe, 8'h00);
      settle();
      acc(1'b0, a, v & ~pl, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd8();
      pl = rnd8();
      @(posedge ref_clk);
      port1In <= pl;
      acc(1'b1, PPA_ADDR_PORT1, v, 1'b1);
      cmp_pin(port1AnalogSel, v);
      settle();
      cmp_pin(port1AltIn, pl & v & 8'h23);
      acc(1'b0, PPA_ADDR_PORT1, pl, 1'b1);
    end
    @(posedge ref_clk);
    altPort3Enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = rnd8();
      a = rnd8();
      pl = rnd8();
      @(posedge ref_clk);
      port3AltOut <= a;
      pullLow <= pl;
      acc(1'b1, PPA_ADDR_PORT3, v, 1'b1);
      cmp_pin(port3Out, v & a);
      cmp_pin(port3Oe, ~(v & a));
      settle();
      cmp_pin(port3AltIn, v & a & ~pl);
    end
    @(posedge ref_clk);
    altPort3Enable <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      v = rnd8();
      a = rnd8();
      pl = rnd8();
      @(posedge ref_clk);
      extBusActive <= 1'b1;
      extBusAddrPhase <= 1'b1;
      extBusWide <= i[0];
      extBusAddr <= {v, a, pl};
      extBusWdata <= ~a;
      @(negedge ref_clk);
      cmp_pin(port0Out & port0Oe, pl);
      cmp_pin(port0Oe & port2Oe, 8'hFF);
      cmp_pin(port2Out, i[0] ? v : a);
      @(posedge ref_clk);
      extBusAddrPhase <= 1'b0;
      extBusWrite <= 1'b1;
      @(negedge ref_clk);
      cmp_pin(port0Out & port0Oe, ~a);
      cmp_pin(port2Out, a);
      @(posedge ref_clk);
      extBusWrite <= 1'b0;
      pullLow <= pl;
      settle();
      cmp_pin(extBusRdata, ~pl);
    end
    @(posedge ref_clk);
    extBusActive <= 1'b0;
    acc(1'b1, 8'h55, 8'hA5, 1'b0);
    acc(1'b0, 8'h55, 8'hA5, 1'b0);
    cmp_pin({7'h00, regHit} | regRdata, 8'h00);
    cmp_pin(8'(expQ.size()), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire

// [verif/ppa_pin_model.sv]
// Purpose: far-side pin model for the parallel ports and aux pads
// Assumes: external pull-ups on ports zero, two and three
// Notes:   aux pads have no pull, so released pads toggle
`timescale 1ns/100ps
`default_nettype none
module ppa_pin_model (
  // clock and far-side sinks
  input  wire logic       ref_clk,
  input  wire logic [7:0] pullLow,
  // device drive
  input  wire logic [7:0] port0Out,
  input  wire logic [7:0] port0Oe,
  input  wire logic [7:0] port2Out,
  input  wire logic [7:0] port2Oe,
  input  wire logic [7:0] port3Out,
  input  wire logic [7:0] port3Oe,
  input  wire logic [1:0] auxPadOut,
  input  wire logic [1:0] auxPadOe,
  // resolved pin levels
  output logic      [7:0] port0In,
  output logic      [7:0] port2In,
  output logic      [7:0] port3In,
  output logic      [1:0] auxPadIn
);
  logic [1:0] floatPat = 2'h0;
  always @(posedge ref_clk) floatPat <= ~floatPat;
  // released pins read high unless the far device sinks them
  assign port0In = (port0Oe & port0Out) | (~port0Oe & ~pullLow);
  assign port2In = (port2Oe & port2Out) | (~port2Oe & ~pullLow);
  assign port3In = (port3Oe & port3Out) | (~port3Oe & ~pullLow);
  // no pull on aux pads: never show a held value when released
  assign auxPadIn = (auxPadOe & auxPadOut) | (~auxPadOe & floatPat);
endmodule
`default_nettype wire
